/* src/pca_clock_adjust.sv */
// time clock frequency trim, compare/reload, user address registers and interrupt
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: every cycle the frequency increment adds into the fractional accumulator
// R2: time advances at the nominal 100MHz rate, trimmed by accumulator carries
// R3: time is compared to the 64-bit target; a match raises a compare event
// R4: a new target takes effect only once both halves are written
// R5: upper target word holds bits 63:32, lower word bits 31:0
// R6: each compare event updates the target from the reload value; a target commit in the same cycle takes priority
// R7: one configuration bit chooses reload or add on a compare event
// R8: add mode adds only the lower 32 reload bits; reload loads all 64
// R9: a new reload value takes effect only once both halves are written
// R10: the user address is 48 bits: 16-bit upper field plus 32-bit lower
// R11: frames addressed to the user address are flagged as time packets
// R12: each port has its own user address enable bit
// R13: port 2 user address enable is configuration bit 26
// R14: the running time loads only after both of its halves are written
// R15: a compare event sets a sticky flag that drives the interrupt when enabled
// R16: the target update is applied in the match cycle itself
module pca_clock_adjust
  import pca_pkg::*;
#(
  parameter int PORTS = 2
)
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [8:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [PORTS*48-1:0] dest_addr_i,
  output logic [PORTS-1:0] time_pkt_o,
  output logic [63:0] time_o,
  output logic cmp_event_o,
  output logic irq_o
);
  logic [31:0] freq_inc_r;
  logic [31:0] accum_r;
  logic [32:0] accum_sum;
  logic [63:0] time_r;
  logic [63:0] time_nxt;
  logic [63:0] target_r;
  logic [63:0] reload_r;
  logic [15:0] uaddr_upper_r;
  logic [31:0] uaddr_lower_r;
  logic [31:0] cfg_r;
  logic [31:0] status_r;
  logic [31:0] mask_r;
  logic [31:0] rdata_r;
  logic cmp_event_r;
  logic match;
  logic [63:0] tgt_staged;
  logic [63:0] rld_staged;
  logic [63:0] time_staged;
  logic tgt_commit;
  logic rld_commit;
  logic time_commit;
  logic [PORTS-1:0] port_en;

  // strobe and address are passed in so that connections built from this follow them
  function automatic logic wr_hit(input logic wr, input logic [8:0] addr, input logic [8:0] ofs);
    return wr && (addr == ofs);
  endfunction : wr_hit

  // R4: target pair
  pca_pair_reg u_target
  (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .wr_upper_i(wr_hit(reg_wr_i, reg_addr_i, PCA_OFS_TGT_UPPER)),
    .wr_lower_i(wr_hit(reg_wr_i, reg_addr_i, PCA_OFS_TGT_LOWER)),
    .wdata_i(reg_wdata_i),
    .staged_o(tgt_staged),
    .commit_o(tgt_commit)
  );

  // R9: reload pair
  pca_pair_reg u_reload
  (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .wr_upper_i(wr_hit(reg_wr_i, reg_addr_i, PCA_OFS_RLD_UPPER)),
    .wr_lower_i(wr_hit(reg_wr_i, reg_addr_i, PCA_OFS_RLD_LOWER)),
    .wdata_i(reg_wdata_i),
    .staged_o(rld_staged),
    .commit_o(rld_commit)
  );

  // R14: time load pair
  pca_pair_reg u_time
  (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .wr_upper_i(wr_hit(reg_wr_i, reg_addr_i, PCA_OFS_TIME_UPPER)),
    .wr_lower_i(wr_hit(reg_wr_i, reg_addr_i, PCA_OFS_TIME_LOWER)),
    .wdata_i(reg_wdata_i),
    .staged_o(time_staged),
    .commit_o(time_commit)
  );

  // R1: fractional accumulator, carry out trims the rate
  assign accum_sum = {1'b0, accum_r} + {1'b0, freq_inc_r};

  // R2: nominal step per clock, plus one unit on each accumulator carry
  assign time_nxt = time_r + PCA_NOMINAL_STEP + {63'h0, accum_sum[32]};

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      accum_r <= PCA_WORD_RESET;
    end
    else
    begin
      accum_r <= accum_sum[31:0];
    end
  end

  // R14: a committed load overrides the advance
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      time_r <= {PCA_WORD_RESET, PCA_WORD_RESET};
    end
    else if (time_commit)
    begin
      time_r <= time_staged;
    end
    else
    begin
      time_r <= time_nxt;
    end
  end

  // R3: continuous compare; time steps by more than one, so match on crossing
  assign match = (time_r < target_r) && (time_nxt >= target_r);

  // R6: target updated on the match cycle, software commit has priority
  // R16: no extra cycle between match and new target
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      target_r <= {PCA_WORD_RESET, PCA_WORD_RESET};
    end
    else if (tgt_commit)
    begin
      target_r <= tgt_staged;
    end
    else if (match)
    begin
      // R7: reload or add select
      // R8: add uses only the lower reload word
      if (cfg_r[PCA_CFG_RELOAD_ADD_BIT])
      begin
        target_r <= reload_r;
      end
      else
      begin
        target_r <= target_r + {32'h00000000, reload_r[31:0]};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      reload_r <= {PCA_WORD_RESET, PCA_WORD_RESET};
    end
    else if (rld_commit)
    begin
      reload_r <= rld_staged;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cmp_event_r <= 1'b0;
    end
    else
    begin
      cmp_event_r <= match;
    end
  end

  // plain writable registers
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      freq_inc_r <= PCA_WORD_RESET;
      uaddr_upper_r <= PCA_UADDR_UPPER_RESET;
      uaddr_lower_r <= PCA_WORD_RESET;
      cfg_r <= PCA_CFG_RESET;
      mask_r <= PCA_WORD_RESET;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == PCA_OFS_FREQ_INC)
      begin
        freq_inc_r <= reg_wdata_i;
      end
      else if (reg_addr_i == PCA_OFS_UADDR_UPPER)
      begin
        // R10: only the low 16 bits are kept
        uaddr_upper_r <= reg_wdata_i[PCA_UADDR_UPPER_W-1:0];
      end
      else if (reg_addr_i == PCA_OFS_UADDR_LOWER)
      begin
        uaddr_lower_r <= reg_wdata_i;
      end
      else if (reg_addr_i == PCA_OFS_TS_CONFIG)
      begin
        cfg_r <= reg_wdata_i;
      end
      else if (reg_addr_i == PCA_OFS_IRQ_MASK)
      begin
        mask_r <= reg_wdata_i;
      end
    end
  end

  // R15: sticky flag, a new event wins over a same-cycle clear
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      status_r <= PCA_WORD_RESET;
    end
    else
    begin
      if (wr_hit(reg_wr_i, reg_addr_i, PCA_OFS_IRQ_STATUS))
      begin
        status_r[PCA_IRQ_CMP_BIT] <= status_r[PCA_IRQ_CMP_BIT] & ~reg_wdata_i[PCA_IRQ_CMP_BIT];
      end
      if (match)
      begin
        status_r[PCA_IRQ_CMP_BIT] <= 1'b1;
      end
    end
  end

  assign irq_o = |(status_r & mask_r);

  // read data stands the cycle after the strobe only; unmapped reads as zero
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_r <= PCA_WORD_RESET;
    end
    else if (!reg_rd_i)
    begin
      rdata_r <= PCA_WORD_RESET;
    end
    else if (reg_addr_i == PCA_OFS_TIME_UPPER)
    begin
      rdata_r <= time_r[63:32];
    end
    else if (reg_addr_i == PCA_OFS_TIME_LOWER)
    begin
      rdata_r <= time_r[31:0];
    end
    else if (reg_addr_i == PCA_OFS_FREQ_INC)
    begin
      rdata_r <= freq_inc_r;
    end
    // R5: halves of the active target
    else if (reg_addr_i == PCA_OFS_TGT_UPPER)
    begin
      rdata_r <= target_r[63:32];
    end
    else if (reg_addr_i == PCA_OFS_TGT_LOWER)
    begin
      rdata_r <= target_r[31:0];
    end
    else if (reg_addr_i == PCA_OFS_RLD_UPPER)
    begin
      rdata_r <= reload_r[63:32];
    end
    else if (reg_addr_i == PCA_OFS_RLD_LOWER)
    begin
      rdata_r <= reload_r[31:0];
    end
    else if (reg_addr_i == PCA_OFS_UADDR_UPPER)
    begin
      rdata_r <= {16'h0000, uaddr_upper_r};
    end
    else if (reg_addr_i == PCA_OFS_UADDR_LOWER)
    begin
      rdata_r <= uaddr_lower_r;
    end
    else if (reg_addr_i == PCA_OFS_TS_CONFIG)
    begin
      rdata_r <= cfg_r;
    end
    else if (reg_addr_i == PCA_OFS_IRQ_STATUS)
    begin
      rdata_r <= status_r;
    end
    else if (reg_addr_i == PCA_OFS_IRQ_MASK)
    begin
      rdata_r <= mask_r;
    end
    else
    begin
      rdata_r <= PCA_WORD_RESET;
    end
  end

  // R12: one enable per port
  // R13: port 2 enable at bit 26, port 1 at bit 18
  assign port_en = PORTS'({cfg_r[PCA_CFG_P2_USER_EN_BIT], cfg_r[PCA_CFG_P1_USER_EN_BIT]});

  // R11: destination compare against the user address
  pca_addr_match #(
    .PORTS(PORTS)
  ) u_match
  (
    .user_addr_i({uaddr_upper_r, uaddr_lower_r}),
    .port_en_i(port_en),
    .dest_addr_i(dest_addr_i),
    .match_o(time_pkt_o)
  );

  assign reg_rdata_o = rdata_r;
  assign time_o = time_r;
  assign cmp_event_o = cmp_event_r;

  a_target_pair_hold: assert property ( // R4
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!tgt_commit && !match) |=> $stable(target_r))
    else $error("target changed without commit or match");

  a_target_commit: assert property ( // R4
    @(posedge sys_clk_i) disable iff (!rstn_i)
    tgt_commit |=> (target_r == $past(tgt_staged)))
    else $error("committed target not loaded");

  a_reload_hold: assert property ( // R9
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !rld_commit |=> $stable(reload_r))
    else $error("reload changed without commit");

  a_add_mode: assert property ( // R8
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (match && !tgt_commit && !cfg_r[PCA_CFG_RELOAD_ADD_BIT])
      |=> (target_r == $past(target_r) + {32'h00000000, $past(reload_r[31:0])}))
    else $error("add mode update wrong");

  a_reload_mode: assert property ( // R6
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (match && !tgt_commit && cfg_r[PCA_CFG_RELOAD_ADD_BIT]) |=> (target_r == $past(reload_r)))
    else $error("reload mode update wrong");

  a_event_flag: assert property ( // R15
    @(posedge sys_clk_i) disable iff (!rstn_i)
    match |=> (status_r[PCA_IRQ_CMP_BIT] && cmp_event_o))
    else $error("compare event not flagged");

  a_irq_level: assert property ( // R15
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (status_r[PCA_IRQ_CMP_BIT] && mask_r[PCA_IRQ_CMP_BIT]) |-> irq_o)
    else $error("interrupt not raised");

  a_accum_step: assert property ( // R1
    @(posedge sys_clk_i) disable iff (!rstn_i)
    ##1 (accum_r == 32'($past(accum_r) + $past(freq_inc_r))))
    else $error("accumulator did not add increment");

  a_time_advance: assert property ( // R2
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!time_commit && freq_inc_r == 32'h00000000) |=> (time_r == $past(time_r) + PCA_NOMINAL_STEP))
    else $error("time did not advance at base rate");

  a_time_pair: assert property ( // R14
    @(posedge sys_clk_i) disable iff (!rstn_i)
    time_commit |=> (time_r == $past(time_staged)))
    else $error("time load not applied");
endmodule : pca_clock_adjust
`default_nettype wire

/* src/pca_pkg.sv */
// package: register map, field positions, reset values for the time clock adjust/compare block
package pca_pkg;
  localparam logic [8:0] PCA_OFS_TIME_UPPER = 9'h170;
  localparam logic [8:0] PCA_OFS_TIME_LOWER = 9'h174;
  localparam logic [8:0] PCA_OFS_FREQ_INC = 9'h178;
  localparam logic [8:0] PCA_OFS_TGT_UPPER = 9'h17C;
  localparam logic [8:0] PCA_OFS_TGT_LOWER = 9'h180;
  localparam logic [8:0] PCA_OFS_RLD_UPPER = 9'h184;
  localparam logic [8:0] PCA_OFS_RLD_LOWER = 9'h188;
  localparam logic [8:0] PCA_OFS_UADDR_UPPER = 9'h18C;
  localparam logic [8:0] PCA_OFS_UADDR_LOWER = 9'h190;
  localparam logic [8:0] PCA_OFS_TS_CONFIG = 9'h194;
  localparam logic [8:0] PCA_OFS_IRQ_STATUS = 9'h198;
  localparam logic [8:0] PCA_OFS_IRQ_MASK = 9'h19C;
  // configuration fields
  localparam int PCA_CFG_P2_USER_EN_BIT = 26;
  localparam int PCA_CFG_P1_USER_EN_BIT = 18;
  localparam int PCA_CFG_RELOAD_ADD_BIT = 0;
  localparam logic [31:0] PCA_CFG_RESET = 32'h00000000;
  localparam logic [31:0] PCA_WORD_RESET = 32'h00000000;
  localparam logic [15:0] PCA_UADDR_UPPER_RESET = 16'h0000;
  localparam int PCA_UADDR_UPPER_W = 16;
  // interrupt status bit of the compare event
  localparam int PCA_IRQ_CMP_BIT = 0;
  // base rate and system clock, in MHz
  localparam int PCA_BASE_RATE_MHZ = 100;
  localparam int PCA_SYS_CLK_MHZ = 10;
  // time units gained per system clock at nominal rate (base rate / clock rate)
  localparam logic [63:0] PCA_NOMINAL_STEP = 64'(PCA_BASE_RATE_MHZ / PCA_SYS_CLK_MHZ);
  // which half of a paired register has been written
  typedef enum logic [1:0] {
    PCA_HALF_NONE = 2'b00,
    PCA_HALF_LOW = 2'b01,
    PCA_HALF_HIGH = 2'b10,
    PCA_HALF_BOTH = 2'b11
  } pca_half_t;
endpackage : pca_pkg

/* src/pca_pair_reg.sv */
// 64-bit register pair that commits only after both halves are written
`timescale 1ns/1ps
`default_nettype none
module pca_pair_reg
  import pca_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic wr_upper_i,
  input wire logic wr_lower_i,
  input wire logic [31:0] wdata_i,
  output logic [63:0] staged_o,
  output logic commit_o
);
  logic [31:0] upper_r;
  logic [31:0] lower_r;
  pca_half_t seen_r;
  pca_half_t seen_nxt;

  always_comb
  begin
    seen_nxt = seen_r;
    if (wr_upper_i)
    begin
      seen_nxt = pca_half_t'(seen_nxt | PCA_HALF_HIGH);
    end
    if (wr_lower_i)
    begin
      seen_nxt = pca_half_t'(seen_nxt | PCA_HALF_LOW);
    end
  end

  // commit pulse in the cycle of the second half's write
  assign commit_o = (seen_nxt == PCA_HALF_BOTH);

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      seen_r <= PCA_HALF_NONE;
    end
    else if (commit_o)
    begin
      seen_r <= PCA_HALF_NONE;
    end
    else
    begin
      seen_r <= seen_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      upper_r <= PCA_WORD_RESET;
      lower_r <= PCA_WORD_RESET;
    end
    else
    begin
      if (wr_upper_i)
      begin
        upper_r <= wdata_i;
      end
      if (wr_lower_i)
      begin
        lower_r <= wdata_i;
      end
    end
  end

  assign staged_o = {wr_upper_i ? wdata_i : upper_r, wr_lower_i ? wdata_i : lower_r};
endmodule : pca_pair_reg
`default_nettype wire

/* src/pca_addr_match.sv */
// user address compare, gated per port
`timescale 1ns/1ps
`default_nettype none
module pca_addr_match
  import pca_pkg::*;
#(
  parameter int PORTS = 2
)
(
  input wire logic [47:0] user_addr_i,
  input wire logic [PORTS-1:0] port_en_i,
  input wire logic [PORTS*48-1:0] dest_addr_i,
  output logic [PORTS-1:0] match_o
);
  genvar p;
  generate
    for (p = 0; p < PORTS; p++)
    begin : g_port
      assign match_o[p] = port_en_i[p] && (dest_addr_i[p*48 +: 48] == user_addr_i);
    end
  endgenerate
endmodule : pca_addr_match
`default_nettype wire

/* test/pca_clock_adjust_tb_top.sv */
// self-checking bench of the time clock adjust/compare block
`timescale 1ns/1ps
`default_nettype none
module pca_clock_adjust_tb_top
  import pca_pkg::*;
;
  logic sys_clk_i;
  logic rstn_i;
  logic [8:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic [95:0] dest_addr_i;
  logic [1:0] time_pkt_o;
  logic [63:0] time_o;
  logic cmp_event_o;
  logic irq_o;
  int miscompares;
  int compares;
  int n;
  logic rd_q;
  logic [31:0] seed_r;
  logic [31:0] exp_q[$];
  logic [63:0] t0;
  logic [63:0] v;
  logic [31:0] u;
  logic [31:0] l;

  pca_clock_adjust #(.PORTS(2)) dut (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .dest_addr_i(dest_addr_i),
    .time_pkt_o(time_pkt_o),
    .time_o(time_o),
    .cmp_event_o(cmp_event_o),
    .irq_o(irq_o)
  );

  function automatic logic [31:0] rnd();
    seed_r = seed_r ^ (seed_r << 13);
    seed_r = seed_r ^ (seed_r >> 17);
    seed_r = seed_r ^ (seed_r << 5);
    return seed_r;
  endfunction : rnd

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // strobes stay up between calls so back-to-back transfers need no gap
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    reg_addr_i <= a;
    reg_wdata_i <= d;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
  endtask : rd

  task automatic cyc(input int k);
    repeat (k)
    begin
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
    end
  endtask : cyc

  task automatic wr64(input logic [8:0] a, input logic [63:0] d);
    wr(a, d[63:32]);
    wr(a + 9'h004, d[31:0]);
  endtask : wr64

  task automatic rd64(input logic [8:0] a, input logic [63:0] e);
    rd(a, e[63:32]);
    rd(a + 9'h004, e[31:0]);
  endtask : rd64

  // strobes are dropped every cycle so a trailing write or read is not repeated while waiting
  task automatic wait_evt(input logic [63:0] e);
    n = 0;
    do
    begin
      cyc(1);
      @(negedge sys_clk_i);
      n++;
    end
    while (cmp_event_o !== 1'b1 && n < 600);
    chk(64'(cmp_event_o), 64'h1);
    chk(time_o, e);
  endtask : wait_evt

  always @(posedge sys_clk_i)
  begin
    rd_q <= reg_rd_i;
  end

  always @(negedge sys_clk_i)
  begin
    if (rd_q === 1'b1 && exp_q.size() > 0)
    begin
      chk({32'h0, reg_rdata_o}, {32'h0, exp_q.pop_front()});
    end
  end

  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    rstn_i = 1'b0;
    reg_addr_i = 9'h000;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    dest_addr_i = '0;
    seed_r = 32'd78321;
    miscompares = 0;
    compares = 0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    // reset values, ending on one unmapped place
    for (int a = 'h178; a <= 'h1A0; a += 4) rd(9'(a), PCA_WORD_RESET);
    v = {rnd(), rnd()};
    wr(PCA_OFS_TGT_UPPER, v[63:32]);
    rd64(PCA_OFS_TGT_UPPER, 64'h0);
    wr(PCA_OFS_TGT_LOWER, v[31:0]);
    rd64(PCA_OFS_TGT_UPPER, v);
    v = {rnd(), rnd()};
    wr(PCA_OFS_RLD_LOWER, v[31:0]);
    rd64(PCA_OFS_RLD_UPPER, 64'h0);
    wr(PCA_OFS_RLD_UPPER, v[63:32]);
    rd64(PCA_OFS_RLD_UPPER, v);
    u = rnd();
    wr(PCA_OFS_FREQ_INC, u);
    rd(PCA_OFS_FREQ_INC, u);
    // half-range addend carries every other cycle, so any even span is exact
    wr(PCA_OFS_FREQ_INC, 32'h80000000);
    cyc(2);
    @(negedge sys_clk_i);
    t0 = time_o;
    cyc(32);
    @(negedge sys_clk_i);
    chk(time_o - t0, PCA_NOMINAL_STEP * 32 + 64'd16);
    wr(PCA_OFS_FREQ_INC, 32'h0);
    cyc(2);
    @(negedge sys_clk_i);
    t0 = time_o;
    wr64(PCA_OFS_RLD_UPPER, 64'h00000001_000001F4);
    wr64(PCA_OFS_TGT_UPPER, t0 + 64'd1005);
    wait_evt(t0 + 64'd1010);
    rd64(PCA_OFS_TGT_UPPER, t0 + 64'd1505);
    rd(PCA_OFS_IRQ_STATUS, 32'h1);
    cyc(1);
    @(negedge sys_clk_i);
    chk(64'(irq_o), 64'h0);
    wr(PCA_OFS_IRQ_MASK, 32'h1);
    cyc(1);
    @(negedge sys_clk_i);
    chk(64'(irq_o), 64'h1);
    wr(PCA_OFS_IRQ_STATUS, 32'h1);
    cyc(1);
    @(negedge sys_clk_i);
    chk(64'(irq_o), 64'h0);
    rd(PCA_OFS_IRQ_STATUS, 32'h0);
    wait_evt(t0 + 64'd1510);
    wr(PCA_OFS_TS_CONFIG, 32'h1 << PCA_CFG_RELOAD_ADD_BIT);
    wr64(PCA_OFS_RLD_UPPER, 64'h00000001_00000BB8);
    wait_evt(t0 + 64'd2010);
    rd64(PCA_OFS_TGT_UPPER, 64'h00000001_00000BB8);
    // steps of 20 against 10 per cycle: an event every other cycle
    wr(PCA_OFS_TS_CONFIG, 32'h0);
    wr64(PCA_OFS_RLD_UPPER, 64'd20);
    @(negedge sys_clk_i);
    t0 = time_o;
    wr64(PCA_OFS_TGT_UPPER, t0 + 64'd105);
    wait_evt(t0 + 64'd110);
    n = 0;
    repeat (20)
    begin
      @(negedge sys_clk_i);
      if (cmp_event_o === 1'b1) n++;
    end
    chk(64'(n), 64'd10);
    chk(64'(irq_o), 64'h1);
    u = rnd();
    l = rnd();
    wr(PCA_OFS_UADDR_UPPER, u);
    wr(PCA_OFS_UADDR_LOWER, l);
    rd(PCA_OFS_UADDR_UPPER, {16'h0, u[15:0]});
    rd(PCA_OFS_UADDR_LOWER, l);
    dest_addr_i <= {u[15:0], l, u[15:0], l};
    for (int e = 0; e < 4; e++)
    begin
      wr(PCA_OFS_TS_CONFIG, (32'(e & 1) << PCA_CFG_P1_USER_EN_BIT) | (32'(e >> 1) << PCA_CFG_P2_USER_EN_BIT));
      cyc(1);
      @(negedge sys_clk_i);
      chk(64'(time_pkt_o), 64'(e));
    end
    @(posedge sys_clk_i);
    dest_addr_i[95] <= ~dest_addr_i[95];
    @(negedge sys_clk_i);
    chk(64'(time_pkt_o), 64'h1);
    v = {rnd(), rnd()};
    wr(PCA_OFS_TIME_UPPER, v[63:32]);
    cyc(1);
    @(negedge sys_clk_i);
    chk(64'(time_o[63:32]), 64'h0);
    wr(PCA_OFS_TIME_LOWER, v[31:0]);
    cyc(1);
    @(negedge sys_clk_i);
    chk(time_o, v);
    cyc(3);
    chk(64'(exp_q.size()), 64'h0);
    wrap_up();
  end
endmodule : pca_clock_adjust_tb_top
`default_nettype wire
